// ---- common/uvr_pkg.sv ----
/*
  constants, field positions and carrier types for the vendor register bank.
  assumes a single 250 MHz clock domain and the ulpi register access decoded upstream.
*/
`default_nettype none
package uvr_pkg;
  localparam logic [5:0] ADDR_TX_BOOST = 6'h31;
  localparam logic [5:0] ADDR_AUDIO = 6'h33;
  localparam logic [5:0] ADDR_RID_WR = 6'h36;
  localparam logic [5:0] ADDR_RID_SET = 6'h37;
  localparam logic [5:0] ADDR_RID_CLR = 6'h38;
  localparam logic [5:0] ADDR_IOP_WR = 6'h39;
  localparam logic [5:0] ADDR_IOP_SET = 6'h3A;
  localparam logic [5:0] ADDR_IOP_CLR = 6'h3B;
  localparam logic [5:0] ADDR_VENDOR_LO = 6'h30;
  localparam logic [5:0] ADDR_VENDOR_HI = 6'h3F;

  localparam logic [7:0] TX_BOOST_MASK = 8'h60;
  localparam logic [7:0] AUDIO_MASK = 8'h0F;
  localparam logic [3:0] AUDIO_KEY = 4'hA;
  localparam logic [7:0] RID_WR_MASK = 8'h70;
  localparam logic [7:0] IOP_MASK = 8'hFE;
  localparam logic [7:0] IOP_RESET = 8'h04;

  localparam int RID_VAL_LSB = 0;
  localparam int RID_DONE_BIT = 3;
  localparam int RID_GO_BIT = 4;
  localparam int RID_IRQEN_BIT = 6;
  localparam int IOP_SWAP_BIT = 1;
  localparam int IOP_SER_LDO_LSB = 2;
  localparam int IOP_PU_PLUS_BIT = 4;
  localparam int IOP_PU_MINUS_BIT = 5;
  localparam int IOP_USB_LDO_LSB = 6;

  localparam logic [1:0] LDO_3V3 = 2'h0;

  localparam int CLK_MHZ = 250;
  localparam int RID_CONV_US = 282;
  localparam int RID_CONV_CYCLES = RID_CONV_US * CLK_MHZ;

  typedef enum logic [1:0] {
    UVR_ACC_WRITE,
    UVR_ACC_SET,
    UVR_ACC_CLEAR
  } uvr_acc_type;

  typedef struct packed {
    logic [1:0] tx_boost;
    logic [3:0] audio_mode_key;
    logic [2:0] id_resistor_result;
    logic id_measure_done;
    logic id_measure_go;
    logic rid_bit5;
    logic id_measure_irq_enable;
    logic id_measure_irq_latch;
    logic [7:0] io_power;
    logic [31:0] conv_count;
    logic [7:0] rd_data;
    logic serial_txen_seen;
  } uvr_state_type;
endpackage
`default_nettype wire

// ---- core/uvr_bank.sv ----
/*
  vendor register bank of a usb transceiver: boost, audio key, id resistor
  measurement control and io/power controls. assumes the ulpi register
  protocol (immediate or extended addressing) is decoded into one-cycle
  read and write strobes with a six bit address; the analog converter
  reports its finished result through conv_result_i.
*/
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RQ1 - immediate and extended addressing reach the same registers identically.
// RQ2 - vendor registers live at 30h to 3Fh, via ordinary immediate accesses.
// RQ3 - bits 6:5 of 31h choose high-speed drive amplitude boost.
// RQ4 - headset audio is on only while 33h bits 3:0 hold 1010.
// RQ5 - id conversion register reads at 36h-38h; write, set, clear there.
// RQ6 - three bit result codes resistance, floating pin or error.
// RQ7 - done flag sets automatically when the 282 us conversion ends.
// RQ8 - done clears on read through conversion register, not carkit status.
// RQ9 - start bit launches measurement and clears itself when finished.
// RQ10 - the link keeps conversion bit 5 at zero.
// RQ11 - done raises alt interrupt when either enable is set.
// RQ12 - io and power register reads at 39h-3Bh; write, set, clear there.
// RQ13 - swap bit exchanges dp and dm, also in uart, never speaker pins.
// RQ14 - uart regulator field resets to 01, applied once transmit enable asserts.
// RQ15 - in usb audio mode the regulator stays at 3.3 volts.
// RQ16 - the link should leave uart mode through the hardware reset pin.
// RQ17 - bits 4 and 5 enable charger pull-ups; uart mode forces both.
// RQ18 - usb regulator field resets to 00, used in sync, serial, low-power modes.
// RQ19 - carkit latch bit 3 sets on done rising while enabled; read clears.
// RQ20 - set access ors data in, clear access clears ones, rest untouched.
// RQ21 - reserved read-only bits read zero and ignore writes.
module uvr_bank
  import uvr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [5:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic carkit_status_rd_i,
  input wire logic carkit_latch_rd_i,
  input wire logic carkit_irq_enable_i,
  input wire logic [2:0] conv_result_i,
  input wire logic serial_mode_i,
  input wire logic serial_transmit_enable_i,
  input wire logic audio_active_i,
  output logic [7:0] reg_rdata_o,
  output logic [1:0] tx_boost_o,
  output logic audio_mode_enable_o,
  output logic id_measure_busy_o,
  output logic [2:0] id_resistor_result_o,
  output logic id_measure_done_o,
  output logic id_measure_irq_latch_o,
  output logic alt_int_o,
  output logic data_pin_exchange_o,
  output logic charger_pullup_plus_o,
  output logic charger_pullup_minus_o,
  output logic [1:0] ldo_select_o
);
  localparam int RES_W = $bits(conv_result_i);
  uvr_state_type st;
  uvr_state_type next_st;
  logic [7:0] rid_reg;
  logic [7:0] rid_upd;
  logic [7:0] io_upd;
  logic [7:0] rd_mux;
  logic conv_end;
  logic vendor_hit;
  logic wr_hit;
  logic rd_hit;
  logic hit_tx_boost;
  logic hit_audio;
  logic hit_rid_wr;
  logic hit_rid_set;
  logic hit_rid_clr;
  logic hit_rid_any;
  logic hit_iop_wr;
  logic hit_iop_set;
  logic hit_iop_clr;
  logic hit_iop_any;
  wire logic [RES_W-1:0] conv_result_sync;

  // extended addresses are translated to the same six bit index upstream see RQ1
  assign vendor_hit = (reg_addr_i >= ADDR_VENDOR_LO) && (reg_addr_i <= ADDR_VENDOR_HI); // see RQ2
  assign wr_hit = reg_wr_i && vendor_hit;
  assign rd_hit = reg_rd_i && vendor_hit;

  // one flag per address keeps the write, read and read-clear paths in step
  always_comb begin
    hit_tx_boost = 1'b0;
    hit_audio = 1'b0;
    hit_rid_wr = 1'b0;
    hit_rid_set = 1'b0;
    hit_rid_clr = 1'b0;
    hit_iop_wr = 1'b0;
    hit_iop_set = 1'b0;
    hit_iop_clr = 1'b0;
    if (reg_addr_i == ADDR_TX_BOOST) begin
      hit_tx_boost = 1'b1;
    end else if (reg_addr_i == ADDR_AUDIO) begin
      hit_audio = 1'b1;
    end else if (reg_addr_i == ADDR_RID_WR) begin
      hit_rid_wr = 1'b1;
    end else if (reg_addr_i == ADDR_RID_SET) begin
      hit_rid_set = 1'b1;
    end else if (reg_addr_i == ADDR_RID_CLR) begin
      hit_rid_clr = 1'b1;
    end else if (reg_addr_i == ADDR_IOP_WR) begin
      hit_iop_wr = 1'b1;
    end else if (reg_addr_i == ADDR_IOP_SET) begin
      hit_iop_set = 1'b1;
    end else if (reg_addr_i == ADDR_IOP_CLR) begin
      hit_iop_clr = 1'b1;
    end
  end
  assign hit_rid_any = hit_rid_wr || hit_rid_set || hit_rid_clr; // see RQ5
  assign hit_iop_any = hit_iop_wr || hit_iop_set || hit_iop_clr; // see RQ12

  // the converter settles on its own timing; a code bit counts once two late stages agree
  // costs four cycles of latency, negligible against the measurement time
  for (genvar b = 0; b < RES_W; b++) begin : g_conv_sync
    logic meta;
    logic sync_a;
    logic sync_b;
    logic held;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        meta <= 1'b0;
        sync_a <= 1'b0;
        sync_b <= 1'b0;
        held <= 1'b0;
      end else begin
        meta <= conv_result_i[b];
        sync_a <= meta;
        sync_b <= sync_a;
        if (sync_a == sync_b) begin
          held <= sync_b;
        end
      end
    end
    assign conv_result_sync[b] = held;
  end

  always_comb begin
    rid_reg = 8'h00;
    rid_reg[RID_VAL_LSB +: 3] = st.id_resistor_result; // see RQ6
    rid_reg[RID_DONE_BIT] = st.id_measure_done;
    rid_reg[RID_GO_BIT] = st.id_measure_go;
    rid_reg[RID_GO_BIT + 1] = st.rid_bit5; // see RQ10
    rid_reg[RID_IRQEN_BIT] = st.id_measure_irq_enable;
  end

  // every bit in RID_WR_MASK or IOP_MASK takes a direct write, a set or a clear the same way see RQ20
  for (genvar b = 0; b < $bits(rid_reg); b++) begin : g_bit_update
    // done and result are never touched through set or clear
    assign rid_upd[b] = !RID_WR_MASK[b] ? rid_reg[b] :
                        hit_rid_wr ? reg_wdata_i[b] :
                        hit_rid_set ? (rid_reg[b] || reg_wdata_i[b]) :
                        hit_rid_clr ? (rid_reg[b] && !reg_wdata_i[b]) : rid_reg[b];
    // reserved positions keep their stored zero whatever the access carries see RQ21
    assign io_upd[b] = !IOP_MASK[b] ? st.io_power[b] :
                       hit_iop_wr ? reg_wdata_i[b] :
                       hit_iop_set ? (st.io_power[b] || reg_wdata_i[b]) :
                       hit_iop_clr ? (st.io_power[b] && !reg_wdata_i[b]) : st.io_power[b];
  end

  assign conv_end = st.id_measure_go && (st.conv_count == 32'(RID_CONV_CYCLES - 1)); // see RQ7

  // read data registered; unmapped vendor addresses return zero see RQ21
  always_comb begin
    rd_mux = 8'h00;
    if (!rd_hit) begin
      rd_mux = 8'h00;
    end else if (hit_tx_boost) begin
      rd_mux = {1'b0, st.tx_boost, 5'h00};
    end else if (hit_audio) begin
      rd_mux = {4'h0, st.audio_mode_key};
    end else if (hit_rid_any) begin
      rd_mux = rid_reg; // see RQ5
    end else if (hit_iop_any) begin
      rd_mux = st.io_power; // see RQ12
    end
  end

  always_comb begin
    logic [7:0] nrid;
    nrid = rid_reg;
    next_st = st;
    next_st.rd_data = st.rd_data;
    // writes: direct, set or clear; reserved bits are masked out see RQ20
    if (wr_hit) begin
      if (hit_tx_boost) begin
        next_st.tx_boost = reg_wdata_i[6:5]; // see RQ3
      end else if (hit_audio) begin
        next_st.audio_mode_key = reg_wdata_i[3:0]; // see RQ21
      end else if (hit_rid_any) begin
        nrid = rid_upd; // see RQ5
        if (hit_rid_wr) begin
          // the result field is writable only directly, never through set or clear
          nrid[RID_VAL_LSB +: 3] = reg_wdata_i[RID_VAL_LSB +: 3];
        end
      end else if (hit_iop_any) begin
        next_st.io_power = io_upd; // see RQ12
      end
    end
    next_st.id_resistor_result = nrid[RID_VAL_LSB +: 3];
    next_st.id_measure_go = nrid[RID_GO_BIT];
    next_st.rid_bit5 = nrid[RID_GO_BIT + 1];
    next_st.id_measure_irq_enable = nrid[RID_IRQEN_BIT];
    // converter counts while start is high; a fresh start restarts the count see RQ9
    if (st.id_measure_go && !conv_end) begin
      next_st.conv_count = st.conv_count + 32'h0000_0001;
    end else begin
      next_st.conv_count = 32'h0000_0000;
    end
    // done read clears first, so a finishing conversion in the same cycle wins see RQ8
    if (reg_rd_i && hit_rid_any) begin
      next_st.id_measure_done = 1'b0;
    end
    if (conv_end) begin
      next_st.id_measure_go = 1'b0; // see RQ9
      next_st.id_measure_done = 1'b1; // see RQ7
      next_st.id_resistor_result = conv_result_sync; // see RQ6
    end
    // latch on done rising while either enable is set; event beats the read clear see RQ19
    if (carkit_latch_rd_i) begin
      next_st.id_measure_irq_latch = 1'b0;
    end
    if (next_st.id_measure_done && !st.id_measure_done &&
        (st.id_measure_irq_enable || carkit_irq_enable_i)) begin
      next_st.id_measure_irq_latch = 1'b1; // see RQ19
    end
    // carkit status reads leave done untouched see RQ8
    if (carkit_status_rd_i) begin
      next_st.id_measure_done = next_st.id_measure_done;
    end
    next_st.serial_txen_seen = serial_mode_i && (st.serial_txen_seen || serial_transmit_enable_i);
    // any read reloads the holding register, so stale data never follows a new read
    if (reg_rd_i) begin
      next_st.rd_data = rd_mux;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st <= '0;
      st.io_power <= IOP_RESET; // see RQ14
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata_o = st.rd_data;
  assign tx_boost_o = st.tx_boost; // see RQ3
  assign audio_mode_enable_o = (st.audio_mode_key == AUDIO_KEY); // see RQ4
  assign id_measure_busy_o = st.id_measure_go;
  assign id_resistor_result_o = st.id_resistor_result;
  assign id_measure_done_o = st.id_measure_done;
  assign id_measure_irq_latch_o = st.id_measure_irq_latch;
  // enables are or'ed so either register can arm the alt interrupt see RQ11
  assign alt_int_o = st.id_measure_irq_latch;
  // speaker routing is outside this swap; only the data pins follow it see RQ13
  assign data_pin_exchange_o = st.io_power[IOP_SWAP_BIT];
  assign charger_pullup_plus_o = st.io_power[IOP_PU_PLUS_BIT] || serial_mode_i; // see RQ17
  assign charger_pullup_minus_o = st.io_power[IOP_PU_MINUS_BIT] || serial_mode_i; // see RQ17

  // audio pins the regulator to 3.3 V; serial field waits for transmit enable see RQ15
  always_comb begin
    if (audio_active_i) begin
      ldo_select_o = LDO_3V3; // see RQ15
    end else if (serial_mode_i && st.serial_txen_seen) begin
      ldo_select_o = st.io_power[IOP_SER_LDO_LSB +: 2]; // see RQ14
    end else begin
      ldo_select_o = st.io_power[IOP_USB_LDO_LSB +: 2]; // see RQ18
    end
  end
endmodule
`default_nettype wire

// ---- tb/uvr_conv_model.sv ----
/* id converter stand-in feeding the measured code.
   assumes the bench picks a legal code; outside a measurement the inverse shows. */
`timescale 1ns/1ps
`default_nettype none
module uvr_conv_model (
  input wire logic busy_i,
  input wire logic [2:0] code_i,
  output logic [2:0] conv_result_o
);
  assign conv_result_o = busy_i ? code_i : ~code_i;
endmodule
`default_nettype wire

// ---- tb/uvr_bank_sva.sv ----
/* port checker for uvr_bank.
   assumes one clock and the async active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module uvr_bank_sva
  import uvr_pkg::*;
(
  input wire logic clk_i, rst_b_i, reg_wr_i, reg_rd_i, carkit_irq_enable_i, serial_mode_i, audio_active_i,
  input wire logic audio_mode_enable_o, id_measure_busy_o, id_measure_done_o, id_measure_irq_latch_o,
  input wire logic charger_pullup_plus_o, charger_pullup_minus_o,
  input wire logic [5:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [1:0] tx_boost_o, ldo_select_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  int n;
  // the count is far beyond a repetition, so it lives here
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) n <= 0;
    else n <= id_measure_busy_o ? n + 1 : 0;
  end
  a_conv_len: assert property (n <= RID_CONV_CYCLES)
    else $error("measurement too long");
  a_done_at_end: assert property ($fell(id_measure_busy_o) |-> id_measure_done_o && n >= RID_CONV_CYCLES - 1)
    else $error("measurement end wrong");
  a_boost_write: assert property (reg_wr_i && reg_addr_i == ADDR_TX_BOOST |=>
    ($past(reg_wdata_i) & TX_BOOST_MASK) == {1'b0, tx_boost_o, 5'h00}) else $error("boost not stored");
  a_audio_key: assert property (reg_wr_i && reg_addr_i == ADDR_AUDIO |=>
    audio_mode_enable_o == (($past(reg_wdata_i) & AUDIO_MASK) == {4'h0, AUDIO_KEY})) else $error("audio key");
  a_done_rd_clr: assert property (reg_rd_i && reg_addr_i == ADDR_RID_WR && !id_measure_busy_o |=>
    !id_measure_done_o) else $error("done not cleared");
  a_latch_on_done: assert property ($rose(id_measure_done_o) && $past(carkit_irq_enable_i) |->
    ##[0:1] id_measure_irq_latch_o) else $error("latch missing");
  a_serial_pullups: assert property (serial_mode_i |-> charger_pullup_plus_o && charger_pullup_minus_o)
    else $error("pullups off");
  a_audio_ldo: assert property (audio_active_i |-> ldo_select_o == LDO_3V3)
    else $error("audio ldo");
  c_end: cover property ($fell(id_measure_busy_o));
  c_audio: cover property (audio_mode_enable_o);
  c_latch: cover property (id_measure_irq_latch_o);
endmodule
bind uvr_bank uvr_bank_sva u_sva (.clk_i, .rst_b_i, .reg_wr_i, .reg_rd_i, .carkit_irq_enable_i, .serial_mode_i,
  .audio_active_i, .audio_mode_enable_o, .id_measure_busy_o, .id_measure_done_o, .id_measure_irq_latch_o,
  .charger_pullup_plus_o, .charger_pullup_minus_o, .reg_addr_i, .reg_wdata_i, .tx_boost_o, .ldo_select_o);
`default_nettype wire

// ---- tb/uvr_bank_tb.sv ----
/* self-checking bench for uvr_bank against an integer model.
   assumes the converter model and the bound checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module uvr_bank_tb
  import uvr_pkg::*;
;
  logic clk = 0, rst_b = 0, wr = 0, rd = 0, srd = 0, lrd = 0, cken = 0, ser = 0, txe = 0, aud = 0;
  logic [5:0] a = 6'h00;
  logic [7:0] wd = 8'h00, rdata;
  logic [2:0] code = 3'h0, conv, res;
  logic [1:0] boost, ldo;
  logic aen, busy, done, latch, alt, swp, pp, pm;
  int fail_count = 0, n_compared = 0, io = 4, d;
  always #2 clk = ~clk;
  uvr_conv_model conv_m (.busy_i(busy), .code_i(code), .conv_result_o(conv));
  uvr_bank uut (.clk_i(clk), .rst_b_i(rst_b), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(a), .reg_wdata_i(wd),
    .carkit_status_rd_i(srd), .carkit_latch_rd_i(lrd), .carkit_irq_enable_i(cken), .conv_result_i(conv),
    .serial_mode_i(ser), .serial_transmit_enable_i(txe), .audio_active_i(aud), .reg_rdata_o(rdata),
    .tx_boost_o(boost), .audio_mode_enable_o(aen), .id_measure_busy_o(busy), .id_resistor_result_o(res),
    .id_measure_done_o(done), .id_measure_irq_latch_o(latch), .alt_int_o(alt), .data_pin_exchange_o(swp),
    .charger_pullup_plus_o(pp), .charger_pullup_minus_o(pm), .ldo_select_o(ldo));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic acc(input logic w, input logic [5:0] ad, input logic [7:0] v);
    @(negedge clk);
    wr = w;
    rd = !w;
    a = ad;
    wd = v;
    @(negedge clk);
    wr = 0;
    rd = 0;
  endtask
  task automatic rchk(input string nm, input logic [5:0] ad, input logic [7:0] e);
    acc(0, ad, 8'h00);
    chk(nm, e, rdata);
  endtask
  task automatic strobe(ref logic s);
    @(negedge clk);
    s = 1;
    @(negedge clk);
    s = 0;
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #(4 * 90000);
    fail_count++;
    give_verdict();
  end
  initial begin
    d = $urandom(32'h702c99f8);
    repeat (6) @(negedge clk);
    rst_b = 1;
    rchk("io", ADDR_IOP_WR, 8'h04);
    chk("ldo", 8'h00, {6'h0, ldo});
    $display("reset test done");
    for (int i = 0; i < 12; i++) begin
      d = $urandom;
      ser = d[16];
      aud = d[17];
      acc(1, ADDR_TX_BOOST, {d[7], i[1:0], d[4:0]});
      acc(1, ADDR_AUDIO, i[0] ? {d[7:4], AUDIO_KEY} : d[7:0]);
      rchk("boost", ADDR_TX_BOOST, {1'b0, i[1:0], 5'h00});
      rchk("audio", ADDR_AUDIO, {4'h0, i[0] ? AUDIO_KEY : d[3:0]});
      chk("key", {7'h0, i[0] || d[3:0] == AUDIO_KEY}, {7'h0, aen});
      chk("boost pin", {6'h0, i[1:0]}, {6'h0, boost});
      acc(1, ADDR_IOP_WR + 6'(i % 3), d[15:8]);
      io = i % 3 == 0 ? d[15:8] & 'hFE : i % 3 == 1 ? io | (d[15:8] & 'hFE) : io & ~d[15:8];
      acc(1, 6'h3C, d[23:16]);
      rchk("io", ADDR_IOP_WR + 6'((i + 1) % 3), io[7:0]);
      chk("pins", {4'h0, io[1], io[4] | ser, io[5] | ser, 1'b0}, {4'h0, swp, pp, pm, 1'b0});
      chk("ldo", {6'h0, aud ? 2'h0 : io[7:6]}, {6'h0, ldo});
    end
    ser = 1;
    aud = 0;
    txe = 1;
    repeat (2) @(negedge clk);
    chk("uart ldo", {6'h0, io[3:2]}, {6'h0, ldo});
    rst_b = 0;
    {ser, txe} = 2'b00;
    @(negedge clk);
    rst_b = 1;
    rchk("io", ADDR_IOP_WR, 8'h04);
    chk("boost rst", 8'h00, {6'h0, boost});
    $display("register test done");
    cken = 1;
    code = d[2:0] == 3'h6 ? 3'h7 : d[2:0];
    acc(1, ADDR_RID_SET, 8'h50);
    chk("busy", 8'h01, {7'h0, busy});
    for (int k = 0; k < 71000 && busy === 1'b1; k++) @(negedge clk);
    strobe(srd);
    chk("flags", 8'h07, {5'h0, done, latch, alt});
    chk("result", {5'h0, code}, {5'h0, res});
    rchk("rid", ADDR_RID_WR, {4'h4, 1'b1, code});
    rchk("rid", ADDR_RID_CLR, {5'h08, code});
    strobe(lrd);
    chk("latch", 8'h00, {7'h0, latch});
    acc(1, ADDR_RID_CLR, 8'h40);
    rchk("rid", ADDR_RID_SET, {5'h00, code});
    $display("measurement test done");
    give_verdict();
  end
endmodule
`default_nettype wire
